// ==== lane_serializer.sv ====
// spreads the eight result words over one to eight output lanes
// assumes: shift_in is a one-cycle enable from host logic on clk_in
`default_nettype none
module lane_serializer (
  input wire logic clk_in,
  input wire logic arst_n_in,
  result_link_if.dst link,
  input wire logic shift_in,
  input wire logic [3:0] lanes_in,
  output logic [sar_seq_pkg::NUM_CH-1:0] sdo_out,
  output logic frame_done_out
);
  import sar_seq_pkg::*;

  logic [NUM_CH-1:0][WORD_W-1:0] word_q;
  logic [3:0] n_q;
  logic [4:0] bit_q;
  logic [2:0] k_q;
  logic active_q;
  logic [NUM_CH-1:0] sdo_q;
  logic done_q;
  logic [4:0] nbit;
  logic [2:0] nk;
  logic last;
  logic [3:0] wpl;

  // lane l carries channels l, l+n, l+2n ... in channel order
  function automatic logic [NUM_CH-1:0] lane_bits(
      input logic [NUM_CH-1:0][WORD_W-1:0] w, input logic [2:0] k,
      input logic [4:0] b, input logic [3:0] n);
    logic [NUM_CH-1:0] r;
    int idx;
    r = HOLD_NONE;
    for (int l = 0; l < NUM_CH; l++) begin
      idx = int'(k) * int'(n) + l;
      if (l < int'(n) && idx < NUM_CH) begin
        r[l] = w[idx][BIT_LAST - int'(b)];
      end
    end
    return r;
  endfunction : lane_bits

  function automatic logic [3:0] clamp_lanes(input logic [3:0] n);
    if (n < LANES_MIN) begin
      return LANES_MIN;
    end
    if (n > LANES_MAX) begin
      return LANES_MAX;
    end
    return n;
  endfunction : clamp_lanes

  always_comb begin
    wpl = 4'((NUM_CH + int'(n_q) - 1) / int'(n_q));
    last = (bit_q == 5'(BIT_LAST)) && ({1'b0, k_q} == wpl - 4'h1);
    if (bit_q == 5'(BIT_LAST)) begin
      nbit = 5'h00;
      nk = k_q + 3'h1;
    end else begin
      nbit = bit_q + 5'h01;
      nk = k_q;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      word_q <= '0;
      n_q <= LANES_MIN;
      bit_q <= 5'h00;
      k_q <= 3'h0;
      active_q <= 1'b0;
      sdo_q <= HOLD_NONE;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (link.load) begin
        word_q <= link.words;
        n_q <= clamp_lanes(lanes_in);
        bit_q <= 5'h00;
        k_q <= 3'h0;
        active_q <= 1'b1;
        sdo_q <= lane_bits(link.words, 3'h0, 5'h00,
                           clamp_lanes(lanes_in));
      end else if (shift_in && active_q) begin
        if (last) begin
          active_q <= 1'b0;
          done_q <= 1'b1;
          sdo_q <= HOLD_NONE;
        end else begin
          bit_q <= nbit;
          k_q <= nk;
          sdo_q <= lane_bits(word_q, nk, nbit, n_q);
        end
      end
    end
  end

  assign sdo_out = sdo_q;
  assign frame_done_out = done_q;

  chk_chan0_first: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    link.load |=> sdo_q[0] == $past(link.words[0][BIT_LAST]))
    else $error("lane 0 did not open with channel 0 msb");

  chk_unused_lanes: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (n_q < LANES_MAX) |-> (sdo_q >> n_q) == HOLD_NONE)
    else $error("lane above the selected count is driving");
endmodule : lane_serializer
`default_nettype wire

// ==== octal_sar_conversion_sequencer.sv ====
// top of the octal sar conversion sequencer
// assumes: convert start and comparator come from outside the clock domain;
// range codes, lane count, shift enable and power requests from host logic
//
// What this block does
// - idle channels stay tracking until convert edge
// - convert rising edge holds all channels, converts
// - one channel at a time on shared dac
// - sixteen step binary search per channel
// - assemble output only after all channels done
// - twenty-four bit result word per channel
// - codes 7,6,3,2 give two's complement
// - unipolar channels give straight binary
// - codes 5,4,1 are unipolar straight binary
// - per-channel range codes latched every conversion
// - disabled channels are skipped in sequence
// - results cleared, fresh sample every conversion
// - one to eight serial output lanes
// - nap and power-down states for idle periods
// - output starts at channel 0, channel order
`default_nettype none
module octal_sar_conversion_sequencer (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic convert_start_in,
  input wire logic comparator_in,
  input wire logic [sar_seq_pkg::CFG_W-1:0] range_cfg_in,
  input wire logic [3:0] lanes_in,
  input wire logic shift_in,
  input wire logic nap_in,
  input wire logic power_down_in,
  output logic [sar_seq_pkg::NUM_CH-1:0] sample_hold_out,
  output logic [sar_seq_pkg::CH_W-1:0] chan_sel_out,
  output logic [sar_seq_pkg::RES_W-1:0] capacitor_dac_out,
  output logic busy_out,
  output logic results_ready_out,
  output logic nap_out,
  output logic power_down_out,
  output logic [sar_seq_pkg::NUM_CH-1:0] sdo_out,
  output logic frame_done_out
);
  import sar_seq_pkg::*;

  typedef enum logic [3:0] {
    st_acquire  = 4'h1,
    st_start    = 4'h2,
    st_wait     = 4'h4,
    st_assemble = 4'h8
  } seq_state_type;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic cnv_meta_q;
  logic cnv_sync_q;
  logic cnv_prev_q;
  logic comp_meta_q;
  logic comp_sync_q;
  logic cnv_rise;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnv_meta_q <= 1'b0;
      cnv_sync_q <= 1'b0;
      cnv_prev_q <= 1'b0;
    end else begin
      cnv_meta_q <= convert_start_in;
      cnv_sync_q <= cnv_meta_q;
      cnv_prev_q <= cnv_sync_q;
    end
  end

  // comparator latency is covered by the engine settle count
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comparator_in;
      comp_sync_q <= comp_meta_q;
    end
  end

  assign cnv_rise = cnv_sync_q && !cnv_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // channel sequencing

  seq_state_type state_q;
  logic [CH_W-1:0] chan_q;
  logic [NUM_CH-1:0][RANGE_W-1:0] range_q;
  logic [NUM_CH-1:0][RES_W-1:0] res_q;
  logic [NUM_CH-1:0] hold_q;
  logic ready_q;
  logic nap_q;
  logic pd_q;
  logic accept;
  logic [3:0] first_ch;
  logic [3:0] next_ch;
  logic [NUM_CH-1:0][RANGE_W-1:0] cfg_now;

  sar_link_if sar_link ();
  result_link_if res_link ();

  // lowest enabled channel at or above from; CH_NONE when none left
  function automatic logic [3:0] next_enabled(
      input logic [NUM_CH-1:0][RANGE_W-1:0] rng, input logic [3:0] from);
    logic [3:0] r;
    r = CH_NONE;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (i >= int'(from) && rng[i] != RANGE_OFF) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : next_enabled

  assign cfg_now = range_cfg_in;
  // a start edge while converting or powered down is dropped
  assign accept = cnv_rise && (state_q == st_acquire) && !power_down_in;
  assign first_ch = next_enabled(cfg_now, 4'h0);
  assign next_ch = next_enabled(range_q, {1'b0, chan_q} + 4'h1);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= st_acquire;
      chan_q <= '0;
    end else begin
      case (state_q)
        st_acquire: begin
          if (accept) begin
            if (first_ch == CH_NONE) begin
              state_q <= st_assemble;
            end else begin
              state_q <= st_start;
              chan_q <= first_ch[CH_W-1:0];
            end
          end
        end
        st_start: begin
          state_q <= st_wait;
        end
        st_wait: begin
          if (sar_link.done) begin
            if (next_ch == CH_NONE) begin
              state_q <= st_assemble;
            end else begin
              state_q <= st_start;
              chan_q <= next_ch[CH_W-1:0];
            end
          end
        end
        st_assemble: begin
          state_q <= st_acquire;
        end
        default: begin
          state_q <= st_acquire;
        end
      endcase
    end
  end

  // a new code set is taken with every accepted start edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      range_q <= '0;
    end else if (accept) begin
      range_q <= cfg_now;
    end
  end

  // held channels go back to tracking once their result is taken; disabled ones only in st_assemble
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_q <= HOLD_NONE;
    end else if (accept) begin
      hold_q <= HOLD_ALL;
    end else if (state_q == st_wait && sar_link.done) begin
      hold_q[chan_q] <= 1'b0;
    end else if (state_q == st_assemble || state_q == st_acquire) begin
      hold_q <= HOLD_NONE;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      res_q <= '0;
    end else if (accept) begin
      res_q <= '0;
    end else if (state_q == st_wait && sar_link.done) begin
      res_q[chan_q] <= format_result(sar_link.result,
                                     range_q[chan_q]);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_q <= 1'b0;
    end else if (state_q == st_assemble) begin
      ready_q <= 1'b1;
    end else if (accept) begin
      ready_q <= 1'b0;
    end
  end

  // nap only while idle; the next start edge wakes it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nap_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      pd_q <= power_down_in && (state_q == st_acquire);
      nap_q <= nap_in && !power_down_in && !accept &&
               (state_q == st_acquire);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // engine and output assembly

  assign sar_link.start = (state_q == st_start);
  assign sar_link.comp = comp_sync_q;

  sar_engine #(
    .SETTLE(SETTLE_CYCLES)
  ) u_engine (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .link(sar_link)
  );

  // word: result, channel number, range code, two spare zero bits
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      res_link.words[i] = {res_q[i], 3'(i), range_q[i], 2'b00};
    end
  end

  assign res_link.load = (state_q == st_assemble);

  lane_serializer u_serializer (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .link(res_link),
    .shift_in(shift_in),
    .lanes_in(lanes_in),
    .sdo_out(sdo_out),
    .frame_done_out(frame_done_out)
  );

  assign sample_hold_out = hold_q;
  assign chan_sel_out = chan_q;
  assign capacitor_dac_out = sar_link.code;
  assign busy_out = (state_q != st_acquire);
  assign results_ready_out = ready_q;
  assign nap_out = nap_q;
  assign power_down_out = pd_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  chk_idle_tracking: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == st_acquire) && $past(state_q == st_acquire) |->
      hold_q == HOLD_NONE)
    else $error("channel held while idle");

  chk_edge_holds_all: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    accept |=> hold_q == HOLD_ALL && state_q != st_acquire)
    else $error("start edge did not hold every channel");

  chk_enabled_only: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == st_wait) |-> range_q[chan_q] != RANGE_OFF)
    else $error("disabled channel entered the search");

  chk_load_after_all: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == st_wait) && sar_link.done && next_ch != CH_NONE |=>
      !res_link.load ##1 state_q == st_wait)
    else $error("output assembled before last channel");

  chk_bipolar_twos: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == st_wait) && sar_link.done && is_bipolar(range_q[chan_q])
      |=> res_q[$past(chan_q)] == ($past(sar_link.result) ^ SIGN_FLIP))
    else $error("bipolar result not two's complement");

  chk_unipolar_straight: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    (state_q == st_wait) && sar_link.done && !is_bipolar(range_q[chan_q])
      |=> res_q[$past(chan_q)] == $past(sar_link.result))
    else $error("unipolar result not straight binary");

  chk_disabled_zero: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    res_link.load |-> (range_q[0] != RANGE_OFF || res_q[0] == RES_ZERO) &&
      (range_q[7] != RANGE_OFF || res_q[7] == RES_ZERO))
    else $error("disabled channel reported nonzero");

  chk_fresh_results: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    accept |=> res_q == '0 && !ready_q)
    else $error("old result carried into new conversion");

  chk_codes_latched: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    accept |=> range_q == $past(cfg_now))
    else $error("range codes not taken at start edge");

  chk_power_down_idle: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    power_down_in && (state_q == st_acquire) |=> state_q == st_acquire
      && pd_q && !nap_q)
    else $error("conversion started while powered down");
endmodule : octal_sar_conversion_sequencer
`default_nettype wire

// ==== octal_sar_conversion_sequencer_bench.sv ====
// self-checking bench for the octal sar conversion sequencer.
// assumes the package, links, design and analog model are compiled first.
`default_nettype none
module octal_sar_conversion_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sar_seq_pkg::*;

  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic convert_start_in = 1'b0;
  logic comp_w;
  logic [CFG_W-1:0] range_cfg_in = '0;
  logic [3:0] lanes_in = 4'h8;
  logic shift_in = 1'b0;
  logic nap_in = 1'b0;
  logic power_down_in = 1'b0;
  logic [NUM_CH-1:0] sample_hold_out;
  logic [CH_W-1:0] chan_sel_out;
  logic [RES_W-1:0] capacitor_dac_out;
  logic busy_out;
  logic results_ready_out;
  logic nap_out;
  logic power_down_out;
  logic [NUM_CH-1:0] sdo_out;
  logic frame_done_out;
  logic [31:0] seed = 32'h24c51450;
  logic [NUM_CH-1:0][RES_W-1:0] track = '0;
  logic [WORD_W-1:0] acc [NUM_CH];
  logic [WORD_W-1:0] exp_q [$];
  logic [WORD_W-1:0] want_w;
  int fail_count = 0;
  int comparisons = 0;
  int bitcnt = 0;
  int slot = 0;
  int lanes_n = 8;

  always #5 clk_in = ~clk_in;

  octal_sar_conversion_sequencer dut (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .convert_start_in(convert_start_in),
    .comparator_in(comp_w),
    .range_cfg_in(range_cfg_in),
    .lanes_in(lanes_in),
    .shift_in(shift_in),
    .nap_in(nap_in),
    .power_down_in(power_down_in),
    .sample_hold_out(sample_hold_out),
    .chan_sel_out(chan_sel_out),
    .capacitor_dac_out(capacitor_dac_out),
    .busy_out(busy_out),
    .results_ready_out(results_ready_out),
    .nap_out(nap_out),
    .power_down_out(power_down_out),
    .sdo_out(sdo_out),
    .frame_done_out(frame_done_out)
  );

  sar_analog_model analog (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .hold_in(sample_hold_out),
    .chan_sel_in(chan_sel_out),
    .dac_in(capacitor_dac_out),
    .track_in(track),
    .comp_out(comp_w)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // ideal search returns the held sample as offset binary
  function automatic logic [WORD_W-1:0] exp_word(input int ch,
      input logic [2:0] rng, input logic [15:0] raw);
    logic [15:0] res;
    res = raw;
    if (rng == 3'h0) begin
      res = 16'h0000;
    end else if (rng inside {3'h7, 3'h6, 3'h3, 3'h2}) begin
      res = raw ^ 16'h8000;
    end
    return {res, ch[2:0], rng, 2'b00};
  endfunction : exp_word

  task automatic check_val(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check_val

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////
  // monitor: old sdo bit is taken at each shift edge, word by word
  always @(posedge clk_in) begin
    if (shift_in) begin
      for (int l = 0; l < NUM_CH; l++) begin
        acc[l] = {acc[l][WORD_W-2:0], sdo_out[l]};
      end
      bitcnt++;
      if (bitcnt == WORD_W) begin
        bitcnt = 0;
        for (int l = 0; l < NUM_CH; l++) begin
          if (l >= lanes_n) begin
            check_val(acc[l], 0);
          end else if (l + slot * lanes_n < NUM_CH) begin
            // an empty queue means an extra word: compare against unknown
            want_w = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            check_val(acc[l], want_w);
          end
        end
        slot++;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic run_conv(input logic [23:0] cfg, input int lanes,
      output int cyc);
    int fe;
    int ch;
    fe = -1;
    cyc = 0;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      seed = lfsr(seed);
      track[c] = seed[15:0];
      if (cfg[3*c +: 3] != 3'h0) begin
        fe = c;
      end
    end
    lanes_in = lanes[3:0];
    range_cfg_in = cfg;
    lanes_n = lanes < 1 ? 1 : (lanes > 8 ? 8 : lanes);
    for (int k = 0; k * lanes_n < NUM_CH; k++) begin
      for (int l = 0; l < lanes_n && l + k * lanes_n < NUM_CH; l++) begin
        ch = l + k * lanes_n;
        exp_q.push_back(exp_word(ch, cfg[3*ch +: 3], track[ch]));
      end
    end
    @(negedge clk_in);
    check_val(sample_hold_out, 8'h00);
    convert_start_in = 1'b1;
    while (busy_out !== 1'b1 && cyc < 10) begin
      @(negedge clk_in);
      cyc++;
    end
    check_val(sample_hold_out, 8'hff);
    check_val(results_ready_out, 1'b0);
    @(negedge clk_in);
    convert_start_in = 1'b0;
    if (fe >= 0) begin
      check_val(chan_sel_out, fe);
      check_val(capacitor_dac_out, 16'h8000);
      repeat (4) @(negedge clk_in);
      // a second edge in mid-conversion must be dropped
      convert_start_in = 1'b1;
    end
    cyc = 0;
    while (results_ready_out !== 1'b1 && cyc < 1000) begin
      @(negedge clk_in);
      cyc++;
      convert_start_in = 1'b0;
    end
    check_val(results_ready_out, 1'b1);
    bitcnt = 0;
    slot = 0;
    shift_in = 1'b1;
    repeat (WORD_W * ((NUM_CH + lanes_n - 1) / lanes_n)) @(negedge clk_in);
    shift_in = 1'b0;
    fe = 0;
    repeat (3) begin
      if (frame_done_out === 1'b1) begin
        fe = 1;
      end
      @(negedge clk_in);
    end
    check_val(fe, 1);
    check_val(exp_q.size(), 0);
    check_val(busy_out, 1'b0);
  endtask : run_conv

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int c7;
    int c1;
    int cz;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    // channel i gets range code i: every code once
    run_conv(24'hfac688, 8, c7);
    run_conv(24'h000000, 3, cz);
    run_conv(24'h000007, 8, c1);
    check_val(c1 < c7, 1);
    check_val(cz < c1, 1);
    for (int n = 0; n < 10; n++) begin
      seed = lfsr(seed);
      run_conv(seed[23:0], n, c1);
    end
    power_down_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check_val(power_down_out, 1'b1);
    check_val(nap_out, 1'b0);
    convert_start_in = 1'b1;
    repeat (6) @(negedge clk_in);
    check_val(busy_out, 1'b0);
    convert_start_in = 1'b0;
    nap_in = 1'b1;
    power_down_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check_val(nap_out, 1'b1);
    check_val(power_down_out, 1'b0);
    nap_in = 1'b0;
    wrap_up();
  end

  // whole run needs well under 20k cycles
  initial begin
    #500000;
    fail_count++;
    wrap_up();
  end
endmodule : octal_sar_conversion_sequencer_bench
`default_nettype wire

// ==== sar_analog_model.sv ====
// analog side of the sequencer: per-channel track/hold and an ideal
// comparator. Assumes hold bits and channel select come from the
// sequencer on clk_in, and track values change only between conversions.
`default_nettype none
module sar_analog_model (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [sar_seq_pkg::NUM_CH-1:0] hold_in,
  input wire logic [sar_seq_pkg::CH_W-1:0] chan_sel_in,
  input wire logic [sar_seq_pkg::RES_W-1:0] dac_in,
  input wire logic [sar_seq_pkg::NUM_CH-1:0][sar_seq_pkg::RES_W-1:0] track_in,
  output logic comp_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import sar_seq_pkg::*;

  logic [NUM_CH-1:0][RES_W-1:0] held_q;

  ////////////////////////////////////////////////////////////////////////
  // follows the input while tracking, freezes once the hold bit is seen
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      held_q <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!hold_in[c]) begin
          held_q[c] <= track_in[c];
        end
      end
    end
  end

  // no settling delay here: the design's own sync stages set the latency
  assign comp_out = held_q[chan_sel_in] >= dac_in;
endmodule : sar_analog_model
`default_nettype wire

// ==== sar_engine.sv ====
// sixteen-step binary search driving the shared capacitor dac
// assumes: comp is already synchronised, high when sample >= dac code
`default_nettype none
module sar_engine #(
  parameter int SETTLE = sar_seq_pkg::SETTLE_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  sar_link_if.engine link
);
  import sar_seq_pkg::*;

  localparam int SAR_CYC = 16 * SETTLE + 1;

  logic busy_q;
  logic [3:0] bit_q;
  logic [3:0] cnt_q;
  logic [RES_W-1:0] trial_q;
  logic [RES_W-1:0] result_q;
  logic done_q;
  logic [RES_W-1:0] keep;

  // drop the trial bit when the sample sits below the dac level
  always_comb begin
    keep = link.comp ? trial_q : (trial_q & ~(16'h0001 << bit_q));
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_q <= 1'b0;
      bit_q <= 4'h0;
      cnt_q <= 4'h0;
      trial_q <= RES_ZERO;
      result_q <= RES_ZERO;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (link.start) begin
        busy_q <= 1'b1;
        bit_q <= 4'hf;
        cnt_q <= 4'h0;
        trial_q <= SIGN_FLIP;
      end else if (busy_q) begin
        if (cnt_q == 4'(SETTLE - 1)) begin
          cnt_q <= 4'h0;
          if (bit_q == 4'h0) begin
            result_q <= keep;
            trial_q <= keep;
            done_q <= 1'b1;
            busy_q <= 1'b0;
          end else begin
            trial_q <= keep | (16'h0001 << (bit_q - 4'h1));
            bit_q <= bit_q - 4'h1;
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

  assign link.code = trial_q;
  assign link.result = result_q;
  assign link.done = done_q;

  chk_search_length: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    link.start |-> ##[SAR_CYC:SAR_CYC] done_q)
    else $error("search did not finish in sixteen steps");

  chk_first_trial: assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    link.start |=> trial_q == SIGN_FLIP && busy_q)
    else $error("search did not open at half scale");
endmodule : sar_engine
`default_nettype wire

// ==== sar_seq_links.sv ====
// carriers between the sequencer and its search engine and serializer
// assumes: all ends share clk_in
`default_nettype none
interface sar_link_if;
  logic start;
  logic comp;
  logic done;
  logic [sar_seq_pkg::RES_W-1:0] code;
  logic [sar_seq_pkg::RES_W-1:0] result;
  modport ctrl (output start, output comp, input done, input code,
                input result);
  modport engine (input start, input comp, output done, output code,
                  output result);
endinterface : sar_link_if

interface result_link_if;
  logic load;
  logic [sar_seq_pkg::NUM_CH-1:0][sar_seq_pkg::WORD_W-1:0] words;
  modport src (output load, output words);
  modport dst (input load, input words);
endinterface : result_link_if
`default_nettype wire

// ==== sar_seq_pkg.sv ====
// constants and format helpers for the octal sar conversion sequencer
// assumes: one 100 MHz clock, all files compiled after this package
`default_nettype none
package sar_seq_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int RES_W = 16;
  localparam int RANGE_W = 3;
  localparam int CFG_W = NUM_CH * RANGE_W;
  localparam int WORD_W = 24;
  localparam int BIT_LAST = WORD_W - 1;
  localparam int SETTLE_CYCLES = 3;
  localparam logic [RANGE_W-1:0] RANGE_OFF = 3'h0;
  localparam logic [RES_W-1:0] SIGN_FLIP = 16'h8000;
  localparam logic [RES_W-1:0] RES_ZERO = 16'h0000;
  localparam logic [NUM_CH-1:0] HOLD_ALL = 8'hff;
  localparam logic [NUM_CH-1:0] HOLD_NONE = 8'h00;
  localparam logic [3:0] LANES_MIN = 4'h1;
  localparam logic [3:0] LANES_MAX = 4'h8;
  localparam logic [3:0] CH_NONE = 4'h8;

  // codes 7, 6, 3 and 2 all have bit 1 set; 5, 4, 1 do not
  function automatic logic is_bipolar(input logic [RANGE_W-1:0] rng);
    return rng[1];
  endfunction : is_bipolar

  // raw search code is offset binary over the span
  function automatic logic [RES_W-1:0] format_result(
      input logic [RES_W-1:0] raw, input logic [RANGE_W-1:0] rng);
    if (rng == RANGE_OFF) begin
      return RES_ZERO;
    end
    if (is_bipolar(rng)) begin
      return raw ^ SIGN_FLIP;
    end
    return raw;
  endfunction : format_result
endpackage : sar_seq_pkg
`default_nettype wire
